// [load_sensor_model.sv]
// Neutral-line current sensor model: base draw plus the draw of every closed load.
module load_sensor_model (
   input wire logic i_clk,
   input wire logic [5:0] i_relay,
   input wire logic [7:0] i_base,
   output logic [7:0] o_current
);
   timeunit 1ns;
   timeprecision 1ns;
   // Load draws in amps; they sum to 27 A so shore power idles without shedding.
   localparam logic [7:0] DRAW [6] = '{8'h08, 8'h07, 8'h05, 8'h04, 8'h02, 8'h01};
   function automatic logic [7:0] total(input logic [5:0] r, input logic [7:0] b);
      total = b;
      for (int k = 0; k < 6; k++) if (r[k]) total += DRAW[k];
   endfunction : total
   // One clock of lag, so a relay change is never seen in the cycle that makes it.
   initial o_current = 8'h00;
   always @(posedge i_clk) o_current <= total(i_relay, i_base);
endmodule : load_sensor_model

// [load_shed_chk.sv]
// Port checker of the load shed controller.
module load_shed_chk #(
   parameter longint MIN_OFF_CYCLES = 50
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_line_one_sense,
   input wire logic i_line_two_sense,
   input wire logic i_line_240v,
   input wire logic i_gen_running,
   input wire logic [7:0] i_total_current,
   input wire logic [5:0] o_relay,
   input wire logic o_power_hold,
   input wire logic o_load_manager_on,
   input wire logic o_meter_blank,
   input wire logic o_ind_50a,
   input wire logic o_ind_gen,
   input wire logic o_ind_shore,
   input wire logic o_ind_30a
);
   timeunit 1ns;
   timeprecision 1ns;
   import load_shed_pkg::*;
   logic [5:0] relay_q;
   logic both;
   longint quiet_q;
   // Service antecedents only count enabled cycles, since a frozen design may not follow its inputs.
   assign both = i_ce && i_line_one_sense && i_line_two_sense && !i_line_240v;
   // Cycles since a relay last opened; starts saturated so closing at power-up is no restore.
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         relay_q <= 6'h00;
         quiet_q <= MIN_OFF_CYCLES;
      end else begin
         relay_q <= o_relay;
         quiet_q <= (|(relay_q & ~o_relay)) ? 0 : (quiet_q < MIN_OFF_CYCLES ? quiet_q + 1 : quiet_q);
      end
   end
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   power_down_a: assert property ((i_ce && !i_line_one_sense && !i_line_two_sense) [*2] |=>
      !o_power_hold && o_relay == 6'h00) else $error("no power down without lines");
   svc_50a_a: assert property ((i_ce && i_line_one_sense && i_line_two_sense && i_line_240v) [*2] |=>
      o_ind_50a && o_meter_blank && &o_relay && !o_load_manager_on) else $error("bad 50 A service outputs");
   svc_gen_a: assert property ((both && i_gen_running) [*2] |=>
      o_ind_gen && !o_meter_blank && &o_relay && !o_load_manager_on) else $error("bad generator outputs");
   svc_shore_a: assert property ((both && !i_gen_running) [*2] |=> o_load_manager_on && o_ind_shore)
      else $error("shore power not managed");
   shed_order_a: assert property (((~o_relay) & (~o_relay + 6'h01)) == 6'h00)
      else $error("relays not opened in shed order");
   one_step_a: assert property (o_load_manager_on && $past(o_load_manager_on) |-> $countones(relay_q ^ o_relay) <= 1)
      else $error("more than one relay changed");
   shed_cause_a: assert property (o_load_manager_on && $past(o_load_manager_on) && |(relay_q & ~o_relay) |->
      $past(i_total_current, 2) > ($past(o_ind_30a) ? LIMIT_30A : LIMIT_20A)) else $error("shed without overload");
   off_time_a: assert property (o_load_manager_on && $past(o_load_manager_on) && |(~relay_q & o_relay) |->
      quiet_q >= MIN_OFF_CYCLES - 3) else $error("load restored too soon");
endmodule : load_shed_chk
bind load_shed_controller load_shed_chk #(.MIN_OFF_CYCLES(MIN_OFF_CYCLES)) u_chk (.*);

// [load_shed_controller.sv]
// Load shed controller: service classification, shedding, learning and restore.
// Function
// - With no line power present the controller powers itself down.
// - On 240 V 50 A service: management off, all relays closed, meter blank.
// - Both lines 120 V with generator running: management off, all relays closed.
// - Both lines 120 V without generator: shore power, management enabled.
// - Service-select press sets the 20 A limit; operator must press it.
// - Entering managed mode starts with all relays closed, current monitored.
// - Only in managed mode, exceeding the active limit starts shedding.
// - Shed one relay at a time in order until under limit or all off.
// - Each shed stores the measured current drop as that load's learned value.
// - Restore last shed load only under limit with headroom at least its value.
// - A shed load stays off at least two minutes.
// - All decisions use the single neutral-line total current measurement.
// - Six relay outputs; 1-4 switch 120 V loads, 5-6 low-voltage changeover.
// - Limit starts at 30 A; each press toggles between 20 A and 30 A, except with no line present (SVC_OFF), when it is held at 30 A.
module load_shed_controller #(
   parameter longint MIN_OFF_CYCLES = load_shed_pkg::MIN_OFF_CYC,
   parameter int SETTLE_CYCLES = load_shed_pkg::SETTLE_CYC
) (
   // Clock, reset and enable.
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_ce,
   // Line and source sensing.
   input wire logic i_line_one_sense,
   input wire logic i_line_two_sense,
   input wire logic i_line_240v,
   input wire logic i_gen_running,
   // Operator switch and current sensor.
   input wire logic i_service_select,
   input wire logic [load_shed_pkg::CUR_W-1:0] i_total_current,
   // Relays and power control.
   output logic [load_shed_pkg::NUM_LOADS-1:0] o_relay,
   output logic o_power_hold,
   output logic o_load_manager_on,
   // Display panel.
   output logic o_meter_blank,
   output logic [load_shed_pkg::CUR_W-1:0] o_meter_value,
   output logic o_ind_50a,
   output logic o_ind_gen,
   output logic o_ind_shore,
   output logic o_ind_30a,
   output logic [load_shed_pkg::NUM_LOADS-1:0] o_ind_load
);
   import load_shed_pkg::*;

   service_t svc_d;
   service_t svc_q;
   mgr_state_t st_q;
   logic limit20_q;
   logic sel_prev_q;
   logic [2:0] shed_cnt_q;
   logic [CUR_W-1:0] before_q;
   logic [CUR_W-1:0] learned_q [NUM_LOADS];
   logic [31:0] off_timer_q [NUM_LOADS];
   logic [31:0] settle_q;
   logic [CUR_W-1:0] limit;
   logic over_limit;
   logic under_limit;
   logic [CUR_W-1:0] spare;
   logic [2:0] last_idx;
   logic can_restore;
   logic managed;

   // Source classification from the line and generator sense inputs.
   always_comb begin
      if (!i_line_one_sense && !i_line_two_sense) begin
         svc_d = SVC_OFF;
      end else if (i_line_240v) begin
         svc_d = SVC_50A;
      end else if (i_line_one_sense && i_line_two_sense && i_gen_running) begin
         svc_d = SVC_GEN;
      end else begin
         svc_d = SVC_SHORE;
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         svc_q <= SVC_OFF;
      end else if (i_ce) begin
         svc_q <= svc_d;
      end
   end

   assign managed = (svc_q == SVC_SHORE);

   // Service select: a rising edge of the press toggles the limit.
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         limit20_q <= 1'b0;
         sel_prev_q <= 1'b0;
      end else if (i_ce) begin
         sel_prev_q <= i_service_select;
         if (svc_q == SVC_OFF) begin
            limit20_q <= 1'b0;
         end else if (i_service_select && !sel_prev_q) begin
            limit20_q <= ~limit20_q;
         end
      end
   end

   // Decisions all use the one neutral-line total measurement.
   assign limit = limit20_q ? LIMIT_20A : LIMIT_30A;
   assign over_limit = (i_total_current > limit);
   assign under_limit = (i_total_current < limit);
   assign spare = under_limit ? (limit - i_total_current) : '0;
   assign last_idx = shed_cnt_q - 3'h1;
   assign can_restore = (shed_cnt_q != 3'h0) && under_limit
                        && (spare >= learned_q[last_idx])
                        && (off_timer_q[last_idx] == 32'h0);

   // Sequencer: shed one load, wait for the current to settle, learn, repeat.
   // The settle wait stops the next decision from seeing a stale reading.
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         st_q <= ST_IDLE;
         shed_cnt_q <= 3'h0;
         before_q <= '0;
         settle_q <= 32'h0;
         for (int i = 0; i < NUM_LOADS; i++) begin
            learned_q[i] <= '0;
         end
      end else if (i_ce) begin
         case (st_q)
            ST_IDLE: begin
               shed_cnt_q <= 3'h0;
               if (managed) begin
                  st_q <= ST_WATCH;
               end
            end
            ST_WATCH: begin
               if (!managed) begin
                  st_q <= ST_IDLE;
               end else if (over_limit && shed_cnt_q != RELAYS_ALL_ON) begin
                  before_q <= i_total_current;
                  shed_cnt_q <= shed_cnt_q + 3'h1;
                  settle_q <= 32'(SETTLE_CYCLES);
                  st_q <= ST_SETTLE;
               end else if (!over_limit && can_restore) begin
                  shed_cnt_q <= last_idx;
                  settle_q <= 32'(SETTLE_CYCLES);
                  st_q <= ST_RESTORE;
               end
            end
            // After a restore the reading is stale until relay and sensor catch up.
            // Waiting here keeps the next headroom check from counting on current that is not yet drawn.
            ST_RESTORE: begin
               if (!managed) begin
                  st_q <= ST_IDLE;
               end else if (settle_q > 32'h1) begin
                  settle_q <= settle_q - 32'h1;
               end else begin
                  st_q <= ST_WATCH;
               end
            end
            ST_SETTLE: begin
               if (!managed) begin
                  st_q <= ST_IDLE;
               end else if (settle_q > 32'h1) begin
                  settle_q <= settle_q - 32'h1;
               end else begin
                  learned_q[last_idx] <= (before_q > i_total_current) ?
                                         (before_q - i_total_current) : '0;
                  st_q <= ST_WATCH;
               end
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Minimum off timers, one per load, loaded when the load is shed.
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         for (int i = 0; i < NUM_LOADS; i++) begin
            off_timer_q[i] <= 32'h0;
         end
      end else if (i_ce) begin
         for (int i = 0; i < NUM_LOADS; i++) begin
            if (st_q == ST_WATCH && managed && over_limit && shed_cnt_q != RELAYS_ALL_ON
                && shed_cnt_q == 3'(i)) begin
               off_timer_q[i] <= 32'(MIN_OFF_CYCLES);
            end else if (off_timer_q[i] != 32'h0) begin
               off_timer_q[i] <= off_timer_q[i] - 32'h1;
            end
         end
      end
   end

   // Relay drive: load k (shed order k) is open while k is below the shed count.
   // Outside managed mode every relay closes, except with no line present (SVC_OFF), when every relay opens.
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_relay <= '0;
         o_ind_load <= '0;
      end else if (i_ce) begin
         for (int i = 0; i < NUM_LOADS; i++) begin
            if (svc_q == SVC_OFF) begin
               o_relay[i] <= 1'b0;
               o_ind_load[i] <= 1'b0;
            end else if (!managed || st_q == ST_IDLE) begin
               o_relay[i] <= 1'b1;
               o_ind_load[i] <= 1'b1;
            end else begin
               o_relay[i] <= (3'(i) >= shed_cnt_q);
               o_ind_load[i] <= (3'(i) >= shed_cnt_q);
            end
         end
      end
   end

   // Power hold, mode flag and display indicators.
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_power_hold <= 1'b0;
         o_load_manager_on <= 1'b0;
         o_meter_blank <= 1'b1;
         o_meter_value <= '0;
         o_ind_50a <= 1'b0;
         o_ind_gen <= 1'b0;
         o_ind_shore <= 1'b0;
         o_ind_30a <= 1'b0;
      end else if (i_ce) begin
         o_power_hold <= (svc_q != SVC_OFF);
         o_load_manager_on <= managed;
         o_meter_blank <= (svc_q == SVC_50A) || (svc_q == SVC_OFF);
         o_meter_value <= i_total_current;
         o_ind_50a <= (svc_q == SVC_50A);
         o_ind_gen <= (svc_q == SVC_GEN);
         o_ind_shore <= managed;
         o_ind_30a <= (svc_q != SVC_OFF) && !limit20_q;
      end
   end
endmodule : load_shed_controller

// [load_shed_pkg.sv]
// Constants and types shared by the load shed controller.
package load_shed_pkg;
   localparam int NUM_LOADS = 6;
   localparam int CUR_W = 8;
   localparam logic [7:0] LIMIT_30A = 8'h1E;
   localparam logic [7:0] LIMIT_20A = 8'h14;
   localparam int CLK_HZ = 20000000;
   localparam int MIN_OFF_S = 120;
   // Two minutes of clocks does not fit a signed 32-bit value, so the product is formed at 64 bits.
   localparam longint MIN_OFF_CYC = longint'(MIN_OFF_S) * longint'(CLK_HZ);
   localparam int SETTLE_US = 500000;
   localparam int SETTLE_CYC = (SETTLE_US / 1000) * (CLK_HZ / 1000);
   localparam logic [2:0] RELAYS_ALL_ON = 3'h6;

   // Service classification.
   typedef enum logic [1:0] {
      SVC_OFF = 2'b00,
      SVC_50A = 2'b01,
      SVC_GEN = 2'b10,
      SVC_SHORE = 2'b11
   } service_t;

   // Management sequencer states.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WATCH = 2'b01,
      ST_SETTLE = 2'b10,
      ST_RESTORE = 2'b11
   } mgr_state_t;
endpackage : load_shed_pkg

// [testbench.sv]
// Testbench: service walk, shedding, 20 A mode and restore of the load shed controller.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import load_shed_pkg::*;
   logic i_mclk = 1'b0, i_rst = 1'b1, l1 = 1'b0, l2 = 1'b0, v240 = 1'b0, gen = 1'b0, sel = 1'b0, ce = 1'b1;
   logic hold, mgr, blank, i50, igen, ishore, i30;
   logic [5:0] relay, ind;
   logic [7:0] base = 8'h00, cur, meter;
   logic [3:0] codes [4] = '{4'h0, 4'hE, 4'hD, 4'hC};
   int n_mismatch = 0;
   int total_checks = 0;
   initial forever #25 i_mclk = ~i_mclk;
   load_shed_controller #(.MIN_OFF_CYCLES(50), .SETTLE_CYCLES(4)) u_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(ce),
      .i_line_one_sense(l1), .i_line_two_sense(l2), .i_line_240v(v240), .i_gen_running(gen),
      .i_service_select(sel), .i_total_current(cur), .o_relay(relay), .o_power_hold(hold), .o_load_manager_on(mgr),
      .o_meter_blank(blank), .o_meter_value(meter), .o_ind_50a(i50), .o_ind_gen(igen), .o_ind_shore(ishore),
      .o_ind_30a(i30), .o_ind_load(ind));
   load_sensor_model u_sense (.i_clk(i_mclk), .i_relay(relay), .i_base(base), .o_current(cur));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge i_mclk);
   endtask : cyc
   // Service code is {line one, line two, 240 V, generator}; outputs settle two edges later.
   task automatic svc(input logic [3:0] s);
      {l1, l2, v240, gen} <= s;
      cyc(4);
   endtask : svc
   task automatic press;
      sel <= 1'b1;
      cyc(2);
      sel <= 1'b0;
      cyc(100);
   endtask : press
   function automatic logic [11:0] exp_svc(input logic [3:0] s);
      if (s[3:2] == 2'b00) return 12'h200;
      if (s[1]) return 12'hB3F;
      return s[0] ? 12'h8BF : 12'hC7F;
   endfunction : exp_svc
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict
   // Main sequence; each load's draw is known to the sensor model, so the end states are fixed.
   initial begin
      void'($urandom(83394));
      cyc(6);
      i_rst <= 1'b0;
      foreach (codes[k]) begin
         svc(codes[k]);
         chk({4'h0, hold, mgr, blank, i50, igen, ishore, relay}, {4'h0, exp_svc(codes[k])});
         chk({10'h000, ind}, {4'h0, exp_svc(codes[k]) & 12'h03F});
      end
      svc(4'hD);
      repeat (8) begin
         base <= 8'($urandom_range(200));
         cyc(3);
         chk({8'h00, meter}, {8'h00, base + 8'h1B});
      end
      $display("test service walk done");
      base <= 8'h00;
      svc(4'hC);
      base <= 8'h19;
      cyc(100);
      chk({9'h000, i30, relay}, 16'h0070);
      press();
      chk({9'h000, i30, relay}, 16'h0000);
      base <= 8'h00;
      cyc(400);
      chk({9'h000, i30, relay}, 16'h003E);
      press();
      chk({9'h000, i30, relay}, 16'h007F);
      $display("test shed and restore done");
      // With the enable low the outputs must hold their shore values although the lines drop.
      ce <= 1'b0;
      svc(4'h0);
      chk({4'h0, hold, mgr, blank, i50, igen, ishore, relay}, {4'h0, exp_svc(4'hC)});
      ce <= 1'b1;
      cyc(4);
      chk({4'h0, hold, mgr, blank, i50, igen, ishore, relay}, {4'h0, exp_svc(4'h0)});
      $display("test clock enable done");
      print_verdict();
   end
   // Watchdog well beyond the roughly 800 cycles that the sequence needs.
   initial begin
      cyc(3000);
      n_mismatch++;
      print_verdict();
   end
endmodule : testbench
